/* File: itqr_pkg.sv */
package itqr_pkg;
  // sizes of the segment table and datapaths
  localparam int NSEG = 4;
  localparam int SEG_W = 2;
  localparam int ADDR_W = 16;
  localparam int CNT_W = 16;
  localparam int NTTL = 8;
  localparam int TIM_W = 24;
  localparam int DEG_W = 9;
  localparam int STR_W = 4;
  // reset values of the trace and sequence settings
  localparam logic [ADDR_W-1:0] LEN_RST = 16'h0064;
  localparam logic [CNT_W-1:0] DWELL_RST = 16'h0001;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0001;
  localparam logic [ADDR_W-1:0] POS_RST = 16'h0000;
  localparam logic ADV_RST = 1'b0;
  // timing: sample clock rate and backplane pulse width
  localparam int CLK_MHZ = 125;
  localparam int STRETCH_NS = 40;
  localparam int STRETCH_CYC = (STRETCH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [STR_W-1:0] STRETCH_LOAD = STR_W'(STRETCH_CYC - 1);
  localparam int DEG_FULL = 360;
  // trigger source and marker selections
  typedef enum logic [2:0] {SRC_IMM, SRC_INT, SRC_EXT, SRC_TTL, SRC_ECH, SRC_CHAIN} itqr_start_e;
  typedef enum logic [1:0] {OSRC_BIT, OSRC_LCOM, OSRC_BCOM, OSRC_INT} itqr_osrc_e;
  typedef enum logic {MARK_POS, MARK_TRIG} itqr_mark_e;
endpackage : itqr_pkg

/* File: itqr_if.sv */
`timescale 1ns/10ps
interface itqr_if;
  // left-to-right chain and phase lock lines from the upstream module
  logic chain_line;
  logic zero_cross_sync;
  logic phase_lock_master;
  // wire-ored lines: each end drives its own term
  logic [itqr_pkg::NTTL-1:0] lead_ttl_drv;
  logic [itqr_pkg::NTTL-1:0] follow_ttl_drv;
  logic [itqr_pkg::NTTL-1:0] ttl_line;
  logic lead_ech_drv;
  logic follow_ech_drv;
  logic end_chain_return_line;

  // resolved line levels
  assign ttl_line = lead_ttl_drv | follow_ttl_drv;
  assign end_chain_return_line = lead_ech_drv | follow_ech_drv;

  modport lead (
    output chain_line, zero_cross_sync, phase_lock_master, lead_ttl_drv, lead_ech_drv,
    input ttl_line, end_chain_return_line
  );
  modport follow (
    input chain_line, zero_cross_sync, phase_lock_master, ttl_line, end_chain_return_line,
    output follow_ttl_drv, follow_ech_drv
  );
endinterface : itqr_if

/* File: itqr_follow.sv */
`timescale 1ns/10ps
module itqr_follow (
  // clock from the shared reference oscillator, reset
  input logic i_clock,
  input logic i_rst,
  // link to the upstream module
  itqr_if.follow link,
  // trace settings
  input logic i_cfg_we,
  input logic [itqr_pkg::ADDR_W-1:0] i_cfg_len,
  input logic [itqr_pkg::CNT_W-1:0] i_cfg_count,
  input logic [itqr_pkg::ADDR_W-1:0] i_cfg_pos,
  // trigger selection
  input itqr_pkg::itqr_start_e i_start_src,
  input logic [2:0] i_ttl_sel,
  input logic i_ext_trig,
  input logic i_init_cont,
  input itqr_pkg::itqr_mark_e i_mark_sel,
  input logic i_trig_mark_en,
  input itqr_pkg::itqr_osrc_e i_out_src,
  input logic i_end_en,
  input logic [itqr_pkg::NTTL-1:0] i_ttl_en,
  // phase lock as slave
  input logic i_phase_lock,
  input logic [itqr_pkg::DEG_W-1:0] i_phase_deg,
  // status
  output logic [itqr_pkg::ADDR_W-1:0] o_addr,
  output logic o_out_trig,
  output logic o_running
);
  logic [itqr_pkg::ADDR_W-1:0] len_r;
  logic [itqr_pkg::CNT_W-1:0] count_r;
  logic [itqr_pkg::ADDR_W-1:0] pos_r;
  logic run_r;
  logic run_nxt;
  logic [itqr_pkg::ADDR_W-1:0] addr_r;
  logic [itqr_pkg::ADDR_W-1:0] addr_nxt;
  logic [itqr_pkg::CNT_W-1:0] burst_r;
  logic [itqr_pkg::CNT_W-1:0] burst_nxt;
  logic trig_r;
  logic ech_r;
  logic [itqr_pkg::NTTL-1:0] ttl_r;
  logic [itqr_pkg::STR_W-1:0] str_r;
  logic [itqr_pkg::ADDR_W-1:0] addr_d_r;

  // trace decode
  wire end_pt = addr_r == len_r - 16'h0001;
  wire burst_done = burst_r >= count_r - 16'h0001;
  wire start_trig = (i_start_src == itqr_pkg::SRC_IMM) ? 1'b1 :
                    (i_start_src == itqr_pkg::SRC_EXT) ? i_ext_trig :
                    (i_start_src == itqr_pkg::SRC_TTL) ? link.ttl_line[i_ttl_sel] :
                    (i_start_src == itqr_pkg::SRC_ECH) ? link.end_chain_return_line :
                    (i_start_src == itqr_pkg::SRC_CHAIN) ? link.chain_line : 1'b0; // RULE_10
  // slave alignment: sync is one sample late and registered once more, so land on offset plus two
  wire lock_eff = i_phase_lock && link.phase_lock_master; // RULE_11 RULE_13
  wire [31:0] off_full = (32'(i_phase_deg) * 32'(len_r)) / 32'(itqr_pkg::DEG_FULL); // RULE_16
  wire [itqr_pkg::ADDR_W-1:0] off = off_full[itqr_pkg::ADDR_W-1:0];
  wire [itqr_pkg::ADDR_W-1:0] off_p2 = (off + 16'h0002 >= len_r) ? off + 16'h0002 - len_r :
                                       off + 16'h0002;

  // markers and qualified trigger
  wire pos_mark = run_r && addr_r == pos_r;
  wire end_mark = run_r && end_pt && i_trig_mark_en;
  wire bit_sig = (i_mark_sel == itqr_pkg::MARK_POS) ? pos_mark : end_mark;
  wire bcom = bit_sig && burst_done; // RULE_18
  wire trig_sel = (i_out_src == itqr_pkg::OSRC_BIT) ? bit_sig :
                  (i_out_src == itqr_pkg::OSRC_BCOM) ? bcom :
                  (i_out_src == itqr_pkg::OSRC_LCOM) ? bit_sig : 1'b0;
  wire str_hold = trig_sel || (str_r != '0);

  // player next state
  always_comb begin
    run_nxt = run_r;
    addr_nxt = addr_r;
    burst_nxt = burst_r;
    if (lock_eff && link.zero_cross_sync) begin
      run_nxt = 1'b1; // RULE_14
      addr_nxt = off_p2; // RULE_16
    end else if (!run_r) begin
      if (start_trig) begin
        run_nxt = 1'b1;
        addr_nxt = '0;
        burst_nxt = '0;
      end
    end else if (!end_pt) begin
      addr_nxt = addr_r + 16'h0001;
    end else if (!burst_done) begin
      addr_nxt = '0;
      burst_nxt = burst_r + 16'h0001;
    end else begin
      addr_nxt = '0;
      burst_nxt = '0;
      run_nxt = i_init_cont || lock_eff;
    end
  end

  // settings
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      len_r <= itqr_pkg::LEN_RST;
      count_r <= itqr_pkg::COUNT_RST;
      pos_r <= itqr_pkg::POS_RST;
    end else if (i_cfg_we) begin
      len_r <= i_cfg_len;
      count_r <= i_cfg_count;
      pos_r <= i_cfg_pos;
    end
  end

  // player and registered trigger outputs
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      run_r <= 1'b0;
      addr_r <= '0;
      burst_r <= '0;
      addr_d_r <= '0;
      trig_r <= 1'b0;
      ech_r <= 1'b0;
      str_r <= '0;
      ttl_r <= '0;
    end else begin
      run_r <= run_nxt;
      addr_r <= addr_nxt;
      burst_r <= burst_nxt;
      addr_d_r <= addr_r; // RULE_19
      trig_r <= trig_sel; // RULE_19
      ech_r <= trig_sel && i_end_en;
      str_r <= trig_sel ? itqr_pkg::STRETCH_LOAD : (str_r != '0 ? str_r - 4'h1 : str_r); // RULE_09
      ttl_r <= str_hold ? i_ttl_en : '0; // RULE_09
    end
  end

  assign link.follow_ech_drv = ech_r;
  assign link.follow_ttl_drv = ttl_r;
  assign o_addr = addr_d_r;
  assign o_out_trig = trig_r;
  assign o_running = run_r;
endmodule : itqr_follow

/* File: itqr_lead.sv */
`timescale 1ns/10ps
// Behaviour
// (RULE_01) selected output trigger always drives chain line
// (RULE_02) position marker selected becomes marker bit
// (RULE_03) loop-done trigger is bit AND loop-complete
// (RULE_04) loop-done only in final repetition, each pass
// (RULE_05) burst-done only in last segment of last burst
// (RULE_06) each segment repeats its dwell count
// (RULE_07) trigger count replays whole sequence per start
// (RULE_08) segment advance defaults to automatic
// (RULE_09) backplane trigger pulses stretched over several samples
// (RULE_10) return-line start source starts on downstream drive
// (RULE_11) phase lock signals travel between adjacent modules
// (RULE_12) all modules clock from master reference oscillator
// (RULE_13) locked traces share point count and rate
// (RULE_14) phase lock aligns slave, otherwise arbitrary offset
// (RULE_15) master zero-cross sync marks trace start
// (RULE_16) slave offset shifts start by trace fraction
// (RULE_17) loop-complete low except during last repetition
// (RULE_18) burst-complete high during last sequence replay
// (RULE_19) qualification and selection registered on sample clock
module itqr_lead (
  // clock from the shared reference oscillator, reset
  input logic i_clock,
  input logic i_rst,
  // link to the downstream module
  itqr_if.lead link,
  // segment table write
  input logic i_cfg_we,
  input logic [itqr_pkg::SEG_W-1:0] i_cfg_seg,
  input logic [itqr_pkg::ADDR_W-1:0] i_cfg_len,
  input logic [itqr_pkg::CNT_W-1:0] i_cfg_dwell,
  input logic [itqr_pkg::ADDR_W-1:0] i_cfg_pos,
  input logic i_cfg_adv_ext,
  // sequence and burst control
  input logic i_seq_mode,
  input logic [itqr_pkg::SEG_W-1:0] i_seq_last,
  input logic [itqr_pkg::CNT_W-1:0] i_trig_count,
  input logic i_init_cont,
  // trigger sources
  input itqr_pkg::itqr_start_e i_start_src,
  input logic [2:0] i_ttl_sel,
  input logic i_ext_trig,
  input logic i_adv_use_int,
  input logic [itqr_pkg::TIM_W-1:0] i_int_period,
  // output trigger selection
  input itqr_pkg::itqr_mark_e i_mark_sel,
  input logic i_trig_mark_en,
  input itqr_pkg::itqr_osrc_e i_out_src,
  input logic i_end_en,
  input logic [itqr_pkg::NTTL-1:0] i_ttl_en,
  // phase lock as master
  input logic i_phase_lock,
  // status
  output logic [itqr_pkg::ADDR_W-1:0] o_addr,
  output logic [itqr_pkg::SEG_W-1:0] o_seg,
  output logic o_out_trig,
  output logic o_position,
  output logic o_trace_start_sync,
  output logic o_running
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT_ADV} itqr_state_e;

  logic [itqr_pkg::ADDR_W-1:0] seg_len_r [itqr_pkg::NSEG];
  logic [itqr_pkg::CNT_W-1:0] seg_dwell_r [itqr_pkg::NSEG];
  logic [itqr_pkg::ADDR_W-1:0] seg_pos_r [itqr_pkg::NSEG];
  logic [itqr_pkg::NSEG-1:0] seg_adv_r;
  itqr_state_e state_r;
  itqr_state_e state_nxt;
  logic [itqr_pkg::ADDR_W-1:0] addr_r;
  logic [itqr_pkg::ADDR_W-1:0] addr_nxt;
  logic [itqr_pkg::SEG_W-1:0] seg_r;
  logic [itqr_pkg::SEG_W-1:0] seg_nxt;
  logic [itqr_pkg::CNT_W-1:0] rep_r;
  logic [itqr_pkg::CNT_W-1:0] rep_nxt;
  logic [itqr_pkg::CNT_W-1:0] burst_r;
  logic [itqr_pkg::CNT_W-1:0] burst_nxt;
  logic [itqr_pkg::TIM_W-1:0] tim_r;
  logic tick_r;
  logic [itqr_pkg::ADDR_W-1:0] addr_d_r;
  logic [itqr_pkg::SEG_W-1:0] seg_d_r;
  logic trig_r;
  logic pos_r;
  logic tss_r;
  logic zcs_r;
  logic lock_r;
  logic ech_r;
  logic [itqr_pkg::NTTL-1:0] ttl_r;
  logic [itqr_pkg::STR_W-1:0] str_r;

  // segment table; advance comes up automatic after reset
  genvar g;
  generate
    for (g = 0; g < itqr_pkg::NSEG; g++) begin : g_seg
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          seg_len_r[g] <= itqr_pkg::LEN_RST;
          seg_dwell_r[g] <= itqr_pkg::DWELL_RST;
          seg_pos_r[g] <= itqr_pkg::POS_RST;
          seg_adv_r[g] <= itqr_pkg::ADV_RST; // RULE_08
        end else if (i_cfg_we && i_cfg_seg == itqr_pkg::SEG_W'(g)) begin
          seg_len_r[g] <= i_cfg_len;
          seg_dwell_r[g] <= i_cfg_dwell;
          seg_pos_r[g] <= i_cfg_pos;
          seg_adv_r[g] <= i_cfg_adv_ext;
        end
      end
    end
  endgenerate

  // current segment decode; single-trace mode plays segment 0 once per burst pass
  wire [itqr_pkg::ADDR_W-1:0] cur_len = seg_len_r[seg_r];
  wire [itqr_pkg::CNT_W-1:0] dwell_raw = seg_dwell_r[seg_r];
  wire [itqr_pkg::CNT_W-1:0] dwell_eff = (!i_seq_mode || dwell_raw == '0) ? 16'h0001 : dwell_raw;
  wire [itqr_pkg::CNT_W-1:0] count_eff = (i_trig_count == '0) ? 16'h0001 : i_trig_count;
  wire running = state_r == ST_RUN;
  wire end_pt = addr_r == cur_len - 16'h0001;
  wire last_seg = !i_seq_mode || seg_r == i_seq_last;
  wire loop_done = rep_r == dwell_eff - 16'h0001; // RULE_17
  wire burst_done = burst_r == count_eff - 16'h0001; // RULE_18
  wire [itqr_pkg::SEG_W-1:0] seg_inc = seg_r + 2'h1;
  wire adv_next = i_seq_mode && seg_adv_r[seg_inc];
  wire adv_first = i_seq_mode && seg_adv_r[0];

  // start and advance trigger selection
  wire start_trig = (i_start_src == itqr_pkg::SRC_IMM) ? 1'b1 :
                    (i_start_src == itqr_pkg::SRC_INT) ? tick_r :
                    (i_start_src == itqr_pkg::SRC_EXT) ? i_ext_trig :
                    (i_start_src == itqr_pkg::SRC_TTL) ? link.ttl_line[i_ttl_sel] :
                    (i_start_src == itqr_pkg::SRC_ECH) ? link.end_chain_return_line : 1'b0; // RULE_10
  wire adv_trig = i_adv_use_int ? tick_r : i_ext_trig;

  // marker qualification; the trace's last point is the trigger marker
  wire pos_mark = running && addr_r == seg_pos_r[seg_r];
  wire end_mark = running && end_pt && i_trig_mark_en;
  wire bit_sig = (i_mark_sel == itqr_pkg::MARK_POS) ? pos_mark : end_mark; // RULE_02
  wire lcom = bit_sig && loop_done; // RULE_03 RULE_04
  wire bcom = lcom && burst_done && last_seg; // RULE_05
  wire trig_sel = (i_out_src == itqr_pkg::OSRC_BIT) ? bit_sig :
                  (i_out_src == itqr_pkg::OSRC_LCOM) ? lcom :
                  (i_out_src == itqr_pkg::OSRC_BCOM) ? bcom : tick_r;
  // backplane lines are slow, so a one-sample trigger is held for several samples
  wire str_hold = trig_sel || (str_r != '0);
  wire trace_start = running && addr_r == '0;

  // playback sequencer
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    seg_nxt = seg_r;
    rep_nxt = rep_r;
    burst_nxt = burst_r;
    case (state_r)
      ST_IDLE: begin
        if (start_trig) begin
          addr_nxt = '0;
          seg_nxt = '0;
          rep_nxt = '0;
          burst_nxt = '0;
          state_nxt = adv_first ? ST_WAIT_ADV : ST_RUN;
        end
      end
      ST_WAIT_ADV: begin
        if (adv_trig) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        if (!end_pt) begin
          addr_nxt = addr_r + 16'h0001;
        end else if (!loop_done) begin
          addr_nxt = '0; // RULE_06
          rep_nxt = rep_r + 16'h0001;
        end else if (!last_seg) begin
          addr_nxt = '0; // RULE_06
          rep_nxt = '0;
          seg_nxt = seg_inc;
          state_nxt = adv_next ? ST_WAIT_ADV : ST_RUN; // RULE_08
        end else if (!burst_done) begin
          addr_nxt = '0; // RULE_07
          rep_nxt = '0;
          seg_nxt = '0;
          burst_nxt = burst_r + 16'h0001;
          state_nxt = adv_first ? ST_WAIT_ADV : ST_RUN;
        end else begin
          addr_nxt = '0;
          rep_nxt = '0;
          seg_nxt = '0;
          burst_nxt = '0;
          state_nxt = i_init_cont ? (adv_first ? ST_WAIT_ADV : ST_RUN) : ST_IDLE;
        end
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      addr_r <= '0;
      seg_r <= '0;
      rep_r <= '0;
      burst_r <= '0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      seg_r <= seg_nxt;
      rep_r <= rep_nxt;
      burst_r <= burst_nxt;
    end
  end

  // internal trigger timer, one-sample tick every period plus one
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tim_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= tim_r == '0;
      tim_r <= (tim_r == '0) ? i_int_period : tim_r - 24'h000001;
    end
  end

  // triggers registered beside the delayed address so they line up
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      addr_d_r <= '0;
      seg_d_r <= '0;
      trig_r <= 1'b0;
      pos_r <= 1'b0;
      tss_r <= 1'b0;
      ech_r <= 1'b0;
    end else begin
      addr_d_r <= addr_r; // RULE_19
      seg_d_r <= seg_r;
      trig_r <= trig_sel; // RULE_19 RULE_01
      pos_r <= pos_mark;
      tss_r <= trace_start;
      ech_r <= trig_sel && i_end_en;
    end
  end

  // backplane drive and phase master outputs
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      str_r <= '0;
      ttl_r <= '0;
      zcs_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      str_r <= trig_sel ? itqr_pkg::STRETCH_LOAD : (str_r != '0 ? str_r - 4'h1 : str_r); // RULE_09
      ttl_r <= str_hold ? i_ttl_en : '0; // RULE_09
      zcs_r <= trace_start && i_phase_lock; // RULE_15 RULE_11
      lock_r <= i_phase_lock; // RULE_12 RULE_13
    end
  end

  // link and status outputs from flip-flops, except o_running, which is decoded from state_r
  assign link.chain_line = trig_r; // RULE_01
  assign link.lead_ech_drv = ech_r;
  assign link.lead_ttl_drv = ttl_r;
  assign link.zero_cross_sync = zcs_r;
  assign link.phase_lock_master = lock_r;
  assign o_addr = addr_d_r;
  assign o_seg = seg_d_r;
  assign o_out_trig = trig_r;
  assign o_position = pos_r;
  assign o_trace_start_sync = tss_r;
  assign o_running = running;
endmodule : itqr_lead

/* File: itqr_chk.sv */
`timescale 1ns/10ps
module itqr_chk (
  // sample clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // link lines
  input wire logic chain_line,
  input wire logic zero_cross_sync,
  input wire logic phase_lock_master,
  input wire logic [itqr_pkg::NTTL-1:0] lead_ttl_drv,
  input wire logic [itqr_pkg::NTTL-1:0] follow_ttl_drv,
  input wire logic lead_ech_drv,
  input wire logic follow_ech_drv
);
  logic [3:0] since_r;
  logic [3:0] f_hi_r;
  wire l_ttl = |lead_ttl_drv;
  wire f_ttl = |follow_ttl_drv;
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // cycles since chain pulse, saturates so it never wraps
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) since_r <= 4'hf;
    else if (chain_line) since_r <= 4'h0;
    else if (since_r != 4'hf) since_r <= since_r + 4'h1;
  end
  // high run length of follower backplane pulse
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) f_hi_r <= 4'h0;
    else if (!f_ttl) f_hi_r <= 4'h0;
    else if (f_hi_r != 4'hf) f_hi_r <= f_hi_r + 4'h1;
  end
  property p_ttl_hold; $rose(l_ttl) |-> l_ttl [*5]; endproperty
  a_ttl_hold: assert property (p_ttl_hold) else $error("lead ttl short");
  property p_ttl_src; l_ttl |-> chain_line || since_r < 4'h4; endproperty
  a_ttl_src: assert property (p_ttl_src) else $error("lead ttl stray");
  property p_ech_chain; lead_ech_drv |-> chain_line; endproperty
  a_ech_chain: assert property (p_ech_chain) else $error("return without chain");
  property p_chain_one; chain_line |=> !chain_line; endproperty
  a_chain_one: assert property (p_chain_one) else $error("chain pulse long");
  property p_zcs_lock; zero_cross_sync |-> phase_lock_master; endproperty
  a_zcs_lock: assert property (p_zcs_lock) else $error("sync while unlocked");
  property p_zcs_gap; zero_cross_sync |=> !zero_cross_sync [*4]; endproperty
  a_zcs_gap: assert property (p_zcs_gap) else $error("sync too close");
  property p_f_width; $fell(f_ttl) |-> f_hi_r >= 4'h5; endproperty
  a_f_width: assert property (p_f_width) else $error("follow ttl short");
  property p_fech_one; $rose(follow_ech_drv) |=> $fell(follow_ech_drv); endproperty
  a_fech_one: assert property (p_fech_one) else $error("return pulse long");
  // main scenarios reached
  c_chain: cover property (chain_line);
  c_zcs: cover property (zero_cross_sync);
  c_ttl: cover property ($rose(l_ttl));
  c_fech: cover property (follow_ech_drv);
endmodule : itqr_chk

/* File: tb.sv */
`timescale 1ns/10ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: %s", $time, m); end end
module tb;
  localparam int WD_CYC = 60000;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  int fail_count = 0;
  int checks_done = 0;
  // lead controls
  logic l_we = 1'b0, l_seq = 1'b0, l_cont = 1'b0, l_tme = 1'b0, l_end = 1'b0, l_lock = 1'b0;
  logic [1:0] l_seg = 2'h0, l_last = 2'h0;
  logic [15:0] l_len = 16'h0005, l_dw = 16'h0001, l_pos = 16'h0000, l_cnt = 16'h0001;
  logic [2:0] l_tsel = 3'h0;
  logic [7:0] l_ten = 8'h00;
  itqr_pkg::itqr_start_e l_src = itqr_pkg::SRC_CHAIN;
  itqr_pkg::itqr_mark_e l_mark = itqr_pkg::MARK_POS;
  itqr_pkg::itqr_osrc_e l_osrc = itqr_pkg::OSRC_BIT;
  // follow controls
  logic f_we = 1'b0, f_cont = 1'b0, f_tme = 1'b0, f_end = 1'b0, f_lock = 1'b0;
  logic [15:0] f_len = 16'h0006, f_cnt = 16'h0001, f_pos = 16'hffff;
  logic [2:0] f_tsel = 3'h0;
  logic [7:0] f_ten = 8'h00;
  logic [8:0] f_deg = 9'h000;
  itqr_pkg::itqr_start_e f_src = itqr_pkg::SRC_INT;
  itqr_pkg::itqr_mark_e f_mark = itqr_pkg::MARK_TRIG;
  itqr_pkg::itqr_osrc_e f_osrc = itqr_pkg::OSRC_BIT;
  // outputs and monitor state
  logic [15:0] la, fa;
  logic [1:0] lseg;
  logic lot, lps, lts, lrun, fot, frun, lr_d, fr_d;
  int n_ch, n_ts, n_ps, n_fo, n_lr, n_fr, ph_off;
  logic al_on = 1'b0, ph_on = 1'b0;
  logic [15:0] exp_pt = 16'h0000;
  itqr_if link ();
  itqr_lead i_itqr_lead (.i_clock(i_clock), .i_rst(i_rst), .link(link.lead), .i_cfg_we(l_we),
    .i_cfg_seg(l_seg), .i_cfg_len(l_len), .i_cfg_dwell(l_dw), .i_cfg_pos(l_pos),
    .i_cfg_adv_ext(1'b0), .i_seq_mode(l_seq), .i_seq_last(l_last), .i_trig_count(l_cnt),
    .i_init_cont(l_cont), .i_start_src(l_src), .i_ttl_sel(l_tsel), .i_ext_trig(1'b0),
    .i_adv_use_int(1'b0), .i_int_period(24'h000010), .i_mark_sel(l_mark), .i_trig_mark_en(l_tme),
    .i_out_src(l_osrc), .i_end_en(l_end), .i_ttl_en(l_ten), .i_phase_lock(l_lock), .o_addr(la),
    .o_seg(lseg), .o_out_trig(lot), .o_position(lps), .o_trace_start_sync(lts), .o_running(lrun));
  itqr_follow i_itqr_follow (.i_clock(i_clock), .i_rst(i_rst), .link(link.follow),
    .i_cfg_we(f_we), .i_cfg_len(f_len), .i_cfg_count(f_cnt), .i_cfg_pos(f_pos),
    .i_start_src(f_src), .i_ttl_sel(f_tsel), .i_ext_trig(1'b0), .i_init_cont(f_cont),
    .i_mark_sel(f_mark), .i_trig_mark_en(f_tme), .i_out_src(f_osrc), .i_end_en(f_end),
    .i_ttl_en(f_ten), .i_phase_lock(f_lock), .i_phase_deg(f_deg), .o_addr(fa),
    .o_out_trig(fot), .o_running(frun));
  itqr_chk i_itqr_chk (.i_clock(i_clock), .i_rst(i_rst), .chain_line(link.chain_line),
    .zero_cross_sync(link.zero_cross_sync), .phase_lock_master(link.phase_lock_master),
    .lead_ttl_drv(link.lead_ttl_drv), .follow_ttl_drv(link.follow_ttl_drv),
    .lead_ech_drv(link.lead_ech_drv), .follow_ech_drv(link.follow_ech_drv));
  // sample clock
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  // event counts and per-cycle alignment checks
  always @(posedge i_clock) begin
    if (link.chain_line === 1'b1) n_ch++;
    if (lts === 1'b1) n_ts++;
    if (lps === 1'b1) n_ps++;
    if (fot === 1'b1) n_fo++;
    if (lrun === 1'b1 && lr_d !== 1'b1) n_lr++;
    if (frun === 1'b1 && fr_d !== 1'b1) n_fr++;
    lr_d = lrun;
    fr_d = frun;
    if (al_on && link.chain_line === 1'b1)
      `CHK({lot, lseg, la}, {1'b1, 2'h1, exp_pt}, "trigger misaligned")
    if (l_end && link.chain_line === 1'b1)
      `CHK(link.end_chain_return_line, 1'b1, "return line missing")
    if (ph_on)
      `CHK(fa, 16'((int'(la) + ph_off) % int'(itqr_pkg::LEN_RST)), "slave phase")
  end
  // chain pulses expected over all c bursts of one start
  function automatic int exp_chain(itqr_pkg::itqr_osrc_e os, itqr_pkg::itqr_mark_e mk,
      int d0, int d1, int c);
    if (os == itqr_pkg::OSRC_BCOM) return 1;
    if (os == itqr_pkg::OSRC_LCOM) return (mk == itqr_pkg::MARK_POS) ? c : 2 * c;
    return (mk == itqr_pkg::MARK_POS) ? c * d1 : c * (d0 + d1);
  endfunction : exp_chain
  task automatic do_reset();
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
  endtask : do_reset
  // extra edge after each write so the strobe never toggles twice at once
  task automatic lwr(input logic [1:0] s, input logic [15:0] n, d, p);
    l_we <= 1'b1;
    l_seg <= s;
    l_len <= n;
    l_dw <= d;
    l_pos <= p;
    @(posedge i_clock);
    l_we <= 1'b0;
    @(posedge i_clock);
  endtask : lwr
  task automatic fwr(input logic [15:0] n, c);
    f_we <= 1'b1;
    f_len <= n;
    f_cnt <= c;
    @(posedge i_clock);
    f_we <= 1'b0;
    @(posedge i_clock);
  endtask : fwr
  task automatic clr();
    @(negedge i_clock);
    n_ch = 0;
    n_ts = 0;
    n_ps = 0;
    n_fo = 0;
    n_lr = 0;
    n_fr = 0;
    @(posedge i_clock);
  endtask : clr
  task automatic wait_lrun(input logic v);
    int n;
    n = 0;
    while (lrun !== v && n < 5000) begin
      @(posedge i_clock);
      n++;
    end
    `CHK(n < 5000, 1'b1, "run state stuck")
  endtask : wait_lrun
  task automatic seq_test(input itqr_pkg::itqr_osrc_e os, input itqr_pkg::itqr_mark_e mk,
      input int d0, input int d1, input int c, input bit via_ch);
    int l1, p, fc;
    logic [2:0] ts;
    l1 = 5 + $urandom % 8;
    p = $urandom % l1;
    fc = 1 + $urandom % 3;
    ts = 3'($urandom % 8);
    l_seq <= 1'b1;
    l_last <= 2'h1;
    l_cnt <= 16'(c);
    l_mark <= mk;
    l_tme <= (mk == itqr_pkg::MARK_TRIG);
    l_osrc <= os;
    l_tsel <= ts;
    l_ten <= via_ch ? 8'h00 : 8'h01 << ts;
    f_src <= via_ch ? itqr_pkg::SRC_CHAIN : itqr_pkg::SRC_TTL;
    f_tsel <= ts;
    f_ten <= 8'($urandom) & ~(8'h01 << ts);
    f_tme <= 1'b1;
    l_end <= via_ch;
    al_on <= (mk == itqr_pkg::MARK_POS) || (os == itqr_pkg::OSRC_BCOM);
    exp_pt <= (mk == itqr_pkg::MARK_POS) ? 16'(p) : 16'(l1 - 1);
    do_reset();
    lwr(2'h0, 16'(5 + $urandom % 8), 16'(d0), 16'hffff);
    lwr(2'h1, 16'(l1), 16'(d1), 16'(p));
    fwr(16'(6 + $urandom % 6), 16'(fc));
    clr();
    l_src <= itqr_pkg::SRC_IMM;
    wait_lrun(1'b1);
    l_src <= itqr_pkg::SRC_CHAIN;
    wait_lrun(1'b0);
    repeat (120) @(posedge i_clock);
    al_on <= 1'b0;
    `CHK(n_lr, 1, "burst restarted")
    `CHK(n_ts, c * (d0 + d1), "segment repeats")
    `CHK(n_ch, exp_chain(os, mk, d0, d1, c), "chain pulse count")
    if (mk == itqr_pkg::MARK_POS) `CHK(n_ps, c * d1, "position marks")
    if (os == itqr_pkg::OSRC_BCOM) `CHK(n_fo, fc, "follower burst")
    $display("sequence test done, %0d chain pulses", n_ch);
  endtask : seq_test
  // follower answers on the return line, lead restarts from it
  task automatic ping_test();
    l_seq <= 1'b0;
    l_cnt <= 16'h0001;
    l_mark <= itqr_pkg::MARK_TRIG;
    l_tme <= 1'b1;
    l_osrc <= itqr_pkg::OSRC_BIT;
    l_ten <= 8'h00;
    f_src <= itqr_pkg::SRC_CHAIN;
    f_osrc <= itqr_pkg::OSRC_BCOM;
    f_end <= 1'b1;
    f_tme <= 1'b1;
    l_end <= 1'b0;
    f_ten <= 8'h00;
    do_reset();
    lwr(2'h0, 16'(6 + $urandom % 6), 16'h0001, 16'hffff);
    fwr(16'(6 + $urandom % 6), 16'(1 + $urandom % 3));
    clr();
    l_src <= itqr_pkg::SRC_IMM;
    wait_lrun(1'b1);
    l_src <= itqr_pkg::SRC_ECH;
    repeat (1500) @(posedge i_clock);
    `CHK(n_lr > 3 && n_fr > 3, 1'b1, "no alternation")
    $display("return line test done, %0d lead starts", n_lr);
  endtask : ping_test
  // lead keeps running at reset length, follower locks with an offset
  task automatic ph_test(input int deg);
    l_src <= itqr_pkg::SRC_IMM;
    l_cont <= 1'b1;
    l_lock <= 1'b1;
    f_src <= itqr_pkg::SRC_INT;
    f_lock <= 1'b1;
    f_deg <= 9'(deg);
    do_reset();
    repeat (250) @(posedge i_clock);
    @(negedge i_clock);
    ph_off = deg * int'(itqr_pkg::LEN_RST) / 360;
    ph_on = 1'b1;
    repeat (200) @(negedge i_clock);
    ph_on = 1'b0;
    $display("phase test done, %0d degrees", deg);
  endtask : ph_test
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // hang guard
  initial begin
    repeat (WD_CYC) @(posedge i_clock);
    fail_count++;
    close_out();
  end
  // main sequence
  initial begin
    void'($urandom(32'he846));
    seq_test(itqr_pkg::OSRC_BIT, itqr_pkg::MARK_POS, 2, 3, 3, 1'b1);
    seq_test(itqr_pkg::OSRC_LCOM, itqr_pkg::MARK_POS, 2, 3, 3, 1'b0);
    seq_test(itqr_pkg::OSRC_BCOM, itqr_pkg::MARK_POS, 2, 3, 3, 1'b1);
    for (int k = 0; k < 3; k++) begin
      seq_test(itqr_pkg::itqr_osrc_e'(k), itqr_pkg::MARK_TRIG, 1 + $urandom % 4,
        1 + $urandom % 4, 1 + $urandom % 4, k[0]);
    end
    ping_test();
    ph_test(0);
    ph_test(90);
    ph_test($urandom % 360);
    close_out();
  end
endmodule : tb
